// >>> core/sfc_flash_cmd.sv
// Serial flash command interpreter: wipe, deep sleep, wake with signature, command table
//
// Overview of operation
// - Full-array wipe opcode is C7h or 60h; only C7h on 256 KB sector parts.
// - Full-array wipe sets every array bit to one.
// - Wipe runs only if select rises right after exactly eight opcode bits.
// - Wipe starts at select rise; busy flag high while running; latch cleared early.
// - Wipe runs only with all protect bits zero, else silently ignored.
// - Deep sleep opcode B9h, exactly eight bits; entered after a fixed delay.
// - In deep sleep every opcode except ABh is ignored.
// - Power-up always lands in standby, never in deep sleep.
// - Deep sleep request during program, erase or status store is rejected.
// - Standby whenever select is high and nothing runs.
// - Opcode ABh leaves deep sleep after the wake delay, then all commands work.
// - ABh followed by three dummy bytes returns one signature byte on serial out.
// - Serial signature bits change on the falling serial clock edge.
// - Signature is the device part of the sixteen-bit identifier.
// - Serial signature repeats every further eight clocks, parallel every clock, while select is low.
// - Select high ends output; identifier reads leave standby/active by select.
// - Parallel mode gives one whole byte per clock on the parallel bus.
// - Parallel mode entered by 55h, left by 45h or power cycle.
// - Read 03h: three address bytes; fast read 0Bh adds one dummy; endless data.
// - 90h takes three address bytes and streams; 9Fh no address, up to three bytes.
// - Status fetch 05h streams status; status store 01h takes exactly one byte.
// - Block wipe 20h or D8h, only D8h on 256 KB parts; three address bytes.
`timescale 1ns/10ps
module sfc_flash_cmd #(
  parameter bit SECTOR_256K = 1'b0,
  parameter logic [7:0] MAKER_ID = 8'hA5,
  parameter logic [15:0] DEVICE_ID = 16'h3C18,
  parameter int unsigned ARRAY_WIPE_CYC = sfc_pkg::ARRAY_WIPE_CYC,
  parameter int unsigned BLOCK_WIPE_CYC = sfc_pkg::BLOCK_WIPE_CYC,
  parameter int unsigned STATUS_STORE_CYC = sfc_pkg::STATUS_STORE_CYC,
  parameter int unsigned WAKE_CYC = sfc_pkg::WAKE_CYC
) (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic link_sck_i,
  input wire logic cs_n_i,
  input wire logic si_i,
  input wire logic [7:0] rd_data_i,
  output logic so_o,
  output logic so_oe_o,
  output logic [7:0] parallel_out_bus_o,
  output logic parallel_out_oe_o,
  output logic [23:0] rd_addr_o,
  output logic write_in_progress_flag_o,
  output logic write_latch_o,
  output logic [2:0] protect_level_bits_o,
  output logic parallel_mode_o,
  output logic deep_sleep_o,
  output logic standby_o,
  output logic erase_all_o,
  output logic erase_block_o,
  output logic [23:0] erase_addr_o
);
  // MAKER_ID and DEVICE_ID defaults are arbitrary values
  localparam logic [7:0] SIGNATURE = DEVICE_ID[7:0];

  // Refuse counts the busy counter cannot serve
  if (ARRAY_WIPE_CYC < 1 || BLOCK_WIPE_CYC < 1 || STATUS_STORE_CYC < 1 || WAKE_CYC < 1)
  begin : g_chk
    $error("sfc_flash_cmd: every delay count must be at least one cycle");
  end

  sfc_pkg::sfc_link_t lk_q, lk_d;
  sfc_pkg::sfc_frame_t fr_q;
  sfc_pkg::sfc_out_t lo_q;
  sfc_pkg::sfc_core_t c_q, c_d;

  // First output byte position of a command, zero when it returns nothing
  function automatic logic [2:0] data_start(input logic [7:0] op);
    case (op)
      sfc_pkg::OP_STATUS_FETCH_CMD: data_start = sfc_pkg::START_AFTER_OP;
      sfc_pkg::OP_IDENTIFIER_READ: data_start = sfc_pkg::START_AFTER_OP;
      sfc_pkg::OP_READ: data_start = sfc_pkg::START_AFTER_ADDR;
      sfc_pkg::OP_MAKER_DEVICE_ID_READ: data_start = sfc_pkg::START_AFTER_ADDR;
      sfc_pkg::OP_WAKE_AND_SIGNATURE: data_start = sfc_pkg::START_AFTER_ADDR;
      sfc_pkg::OP_FAST_READ: data_start = sfc_pkg::START_AFTER_DUMMY;
      default: data_start = 3'h0;
    endcase
  endfunction

  // Byte a non-array command returns
  function automatic logic [7:0] pick_byte(input logic [7:0] op, input logic [1:0] idx, input logic a0,
                                           input logic [7:0] status);
    case (op)
      sfc_pkg::OP_STATUS_FETCH_CMD: pick_byte = status;
      sfc_pkg::OP_IDENTIFIER_READ:
      begin
        case (idx)
          2'h0: pick_byte = MAKER_ID;
          2'h1: pick_byte = DEVICE_ID[15:8];
          2'h2: pick_byte = DEVICE_ID[7:0];
          default: pick_byte = sfc_pkg::FILL_BYTE;
        endcase
      end
      sfc_pkg::OP_MAKER_DEVICE_ID_READ: pick_byte = (idx[0] ^ a0) ? DEVICE_ID[7:0] : MAKER_ID;
      sfc_pkg::OP_WAKE_AND_SIGNATURE: pick_byte = SIGNATURE;
      default: pick_byte = 8'h00;
    endcase
  endfunction

  // True when the frame held exactly n whole bytes
  function automatic logic frame_is(input sfc_pkg::sfc_frame_t fr, input logic [2:0] n);
    frame_is = (fr.nbytes == n) && (fr.bcnt == 3'h0);
  endfunction

  // Link side: shift in opcode and operands, pick output bytes
  always_comb
  begin
    logic [7:0] sh_n;
    logic [7:0] op_n;
    logic [2:0] first;
    logic ready;
    sh_n = {lk_q.sh[6:0], si_i};
    op_n = lk_q.op;
    first = 3'h0;
    ready = 1'b0;
    lk_d = lk_q;
    lk_d.s1 = c_q.share;
    lk_d.s2 = lk_q.s1;
    lk_d.sh = sh_n;
    lk_d.bcnt = lk_q.bcnt + 3'h1;
    if (lk_q.bcnt == 3'h7)
    begin
      if (lk_q.nbytes != 3'h7)
        lk_d.nbytes = lk_q.nbytes + 3'h1;
      if (lk_q.nbytes == 3'h0)
        op_n = sh_n;
      if (lk_q.nbytes == 3'h1)
        lk_d.arg = sh_n;
      if (lk_q.nbytes >= 3'h1 && lk_q.nbytes <= 3'h3)
        lk_d.addr = {lk_q.addr[15:0], sh_n};
    end
    lk_d.op = op_n;
    // Array byte fetched last edge is consumed now; next address follows
    if (lk_q.fetch)
    begin
      lk_d.tx = {rd_data_i[6:0], 1'b0};
      lk_d.addr = lk_q.addr + 24'h00_0001;
    end
    else
    begin
      lk_d.tx = {lk_q.tx[6:0], 1'b0};
    end
    first = data_start(op_n);
    ready = (first != 3'h0) && (lk_d.nbytes >= first) &&
            (!lk_q.s2.sleep || op_n == sfc_pkg::OP_WAKE_AND_SIGNATURE);
    lk_d.fetch = 1'b0;
    if (ready && (lk_d.bcnt == 3'h0 || (lk_q.s2.par && lk_q.drv)))
    begin
      lk_d.drv = 1'b1;
      lk_d.fetch = (op_n == sfc_pkg::OP_READ) || (op_n == sfc_pkg::OP_FAST_READ);
      // Address bit zero is taken after the last address byte has landed
      if (!lk_d.fetch)
        lk_d.tx = pick_byte(op_n, lk_q.idsel, lk_d.addr[0], lk_q.s2.status);
      if (lk_q.idsel != 2'h3)
        lk_d.idsel = lk_q.idsel + 2'h1;
    end
  end

  // Link state is cleared whenever select is high
  always_ff @(posedge link_sck_i or posedge cs_n_i)
  begin
    if (cs_n_i)
      lk_q <= '0;
    else
      lk_q <= lk_d;
  end

  // Frame summary survives select high; toggle marks a new frame for the core
  always_ff @(posedge link_sck_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      fr_q <= '0;
    end
    else
    begin
      fr_q.tog <= (lk_q.nbytes == 3'h0 && lk_q.bcnt == 3'h0) ? ~fr_q.tog : fr_q.tog;
      fr_q.op <= lk_d.op;
      fr_q.nbytes <= lk_d.nbytes;
      fr_q.bcnt <= lk_d.bcnt;
      fr_q.arg <= lk_d.arg;
      fr_q.addr <= lk_d.addr;
    end
  end

  // Output pins change on the falling clock edge
  always_ff @(negedge link_sck_i or posedge cs_n_i)
  begin
    if (cs_n_i)
      lo_q <= '0;
    else
    begin
      lo_q.so <= lk_q.fetch ? rd_data_i[7] : lk_q.tx[7];
      lo_q.so_oe <= lk_q.drv && !lk_q.s2.par;
      lo_q.pbus <= lk_q.fetch ? rd_data_i : lk_q.tx;
      lo_q.pbus_oe <= lk_q.drv && lk_q.s2.par;
    end
  end

  // Core: frame decode at select rise, busy timing, sleep and wake
  always_comb
  begin
    logic rise;
    logic fresh;
    sfc_pkg::sfc_frame_t frm;
    frm = fr_q;
    rise = c_q.cs2 && !c_q.cs3;
    fresh = rise && (frm.tog != c_q.seen);
    c_d = c_q;
    c_d.cs1 = cs_n_i;
    c_d.cs2 = c_q.cs1;
    c_d.cs3 = c_q.cs2;
    if (rise)
      c_d.seen = frm.tog;
    if (c_q.cnt != 32'h0000_0000)
      c_d.cnt = c_q.cnt - 32'h0000_0001;
    case (c_q.st)
      sfc_pkg::ST_BUSY:
      begin
        if (c_q.cnt == 32'h0000_0000)
        begin
          c_d.st = sfc_pkg::ST_STANDBY;
          c_d.erase_all = 1'b0;
          c_d.erase_blk = 1'b0;
        end
      end
      sfc_pkg::ST_SLEEP_ENTER:
        if (c_q.cnt == 32'h0000_0000)
          c_d.st = sfc_pkg::ST_SLEEP;
      sfc_pkg::ST_WAKE:
        if (c_q.cnt == 32'h0000_0000)
          c_d.st = sfc_pkg::ST_STANDBY;
      default: ;
    endcase
    if (fresh && (c_q.st == sfc_pkg::ST_SLEEP || c_q.st == sfc_pkg::ST_SLEEP_ENTER))
    begin
      // Only the wake opcode is heard while asleep
      if (frm.op == sfc_pkg::OP_WAKE_AND_SIGNATURE && frm.nbytes != 3'h0)
      begin
        c_d.st = sfc_pkg::ST_WAKE;
        c_d.cnt = 32'(WAKE_CYC - 1);
      end
    end
    else if (fresh && c_q.st == sfc_pkg::ST_STANDBY)
    begin
      case (frm.op)
        sfc_pkg::OP_WRITE_ENABLE_CMD:
          c_d.write_latch = frame_is(frm, sfc_pkg::LEN_CMD) ? 1'b1 : c_q.write_latch;
        sfc_pkg::OP_WRITE_DISABLE_CMD:
          c_d.write_latch = frame_is(frm, sfc_pkg::LEN_CMD) ? 1'b0 : c_q.write_latch;
        sfc_pkg::OP_STATUS_STORE_CMD:
        begin
          if (frame_is(frm, sfc_pkg::LEN_STORE) && c_q.write_latch)
          begin
            c_d.bp = frm.arg[sfc_pkg::STAT_PROT_LSB +: sfc_pkg::PROT_W];
            c_d.st = sfc_pkg::ST_BUSY;
            c_d.write_latch = 1'b0;
            c_d.cnt = 32'(STATUS_STORE_CYC - 1);
          end
        end
        sfc_pkg::OP_BLOCK_WIPE, sfc_pkg::OP_BLOCK_WIPE_SMALL:
        begin
          if (frame_is(frm, sfc_pkg::LEN_BLOCK) && c_q.write_latch && c_q.bp == 3'h0 &&
              (frm.op == sfc_pkg::OP_BLOCK_WIPE || !SECTOR_256K))
          begin
            c_d.st = sfc_pkg::ST_BUSY;
            c_d.write_latch = 1'b0;
            c_d.erase_blk = 1'b1;
            c_d.eaddr = frm.addr;
            c_d.cnt = 32'(BLOCK_WIPE_CYC - 1);
          end
        end
        sfc_pkg::OP_FULL_ARRAY_WIPE, sfc_pkg::OP_FULL_ARRAY_WIPE_ALT:
        begin
          if (frame_is(frm, sfc_pkg::LEN_CMD) && c_q.write_latch && c_q.bp == 3'h0 &&
              (frm.op == sfc_pkg::OP_FULL_ARRAY_WIPE || !SECTOR_256K))
          begin
            c_d.st = sfc_pkg::ST_BUSY;
            c_d.write_latch = 1'b0;
            c_d.erase_all = 1'b1;
            c_d.cnt = 32'(ARRAY_WIPE_CYC - 1);
          end
        end
        sfc_pkg::OP_PARALLEL_ENTER:
          c_d.par = frame_is(frm, sfc_pkg::LEN_CMD) ? 1'b1 : c_q.par;
        sfc_pkg::OP_PARALLEL_EXIT:
          c_d.par = frame_is(frm, sfc_pkg::LEN_CMD) ? 1'b0 : c_q.par;
        sfc_pkg::OP_DEEP_SLEEP:
          if (frame_is(frm, sfc_pkg::LEN_CMD))
          begin
            c_d.st = sfc_pkg::ST_SLEEP_ENTER;
            c_d.cnt = 32'(sfc_pkg::SLEEP_ENTRY_CYC - 1);
          end
        default: ;
      endcase
    end
    c_d.write_in_progress_flag = (c_d.st == sfc_pkg::ST_BUSY);
    c_d.deep = (c_d.st == sfc_pkg::ST_SLEEP);
    c_d.standby = c_q.cs2 && (c_d.st == sfc_pkg::ST_STANDBY);
    c_d.share.sleep = (c_d.st == sfc_pkg::ST_SLEEP) || (c_d.st == sfc_pkg::ST_SLEEP_ENTER);
    c_d.share.par = c_d.par;
    c_d.share.status = 8'h00;
    c_d.share.status[sfc_pkg::STAT_BUSY_BIT] = c_d.write_in_progress_flag;
    c_d.share.status[sfc_pkg::STAT_LATCH_BIT] = c_d.write_latch;
    c_d.share.status[sfc_pkg::STAT_PROT_LSB +: sfc_pkg::PROT_W] = c_d.bp;
  end

  // Core register; power-up reset puts the block in standby
  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      c_q <= '0;
      c_q.st <= sfc_pkg::ST_STANDBY;
      c_q.cs1 <= 1'b1;
      c_q.cs2 <= 1'b1;
      c_q.cs3 <= 1'b1;
      c_q.bp <= sfc_pkg::PROT_RESET;
    end
    else
    begin
      c_q <= c_d;
    end
  end

  // Outputs straight from flip-flops
  assign so_o = lo_q.so;
  assign so_oe_o = lo_q.so_oe;
  assign parallel_out_bus_o = lo_q.pbus;
  assign parallel_out_oe_o = lo_q.pbus_oe;
  assign rd_addr_o = lk_q.addr;
  assign write_in_progress_flag_o = c_q.write_in_progress_flag;
  assign write_latch_o = c_q.write_latch;
  assign protect_level_bits_o = c_q.bp;
  assign parallel_mode_o = c_q.par;
  assign deep_sleep_o = c_q.deep;
  assign standby_o = c_q.standby;
  assign erase_all_o = c_q.erase_all;
  assign erase_block_o = c_q.erase_blk;
  assign erase_addr_o = c_q.eaddr;

  // Core-domain checks
  a_powerup_standby: assert property (@(posedge core_clk_i) $fell(reset_i) |->
    (c_q.st == sfc_pkg::ST_STANDBY && !deep_sleep_o && !write_latch_o))
    else $error("not in standby after power-up");
  a_wipe_guards: assert property (@(posedge core_clk_i) disable iff (reset_i)
    $rose(erase_all_o) |-> ($past(c_q.write_latch) && $past(c_q.bp) == 3'h0))
    else $error("array wipe started without latch or with protection");
  a_wipe_opcode_len: assert property (@(posedge core_clk_i) disable iff (reset_i)
    $rose(erase_all_o) |-> ($past(fr_q.nbytes) == sfc_pkg::LEN_CMD && $past(fr_q.bcnt) == 3'h0 &&
    ($past(fr_q.op) == sfc_pkg::OP_FULL_ARRAY_WIPE ||
    (!SECTOR_256K && $past(fr_q.op) == sfc_pkg::OP_FULL_ARRAY_WIPE_ALT))))
    else $error("array wipe from wrong opcode or length");
  a_wipe_flags: assert property (@(posedge core_clk_i) disable iff (reset_i)
    $rose(erase_all_o) |-> (write_in_progress_flag_o && !write_latch_o) ##1 write_in_progress_flag_o)
    else $error("busy flag or latch wrong at wipe start");
  a_busy_end: assert property (@(posedge core_clk_i) disable iff (reset_i)
    $fell(write_in_progress_flag_o) |-> (!erase_all_o && !erase_block_o && $past(c_q.cnt) == 32'h0000_0000))
    else $error("busy flag fell before the count ran out");
  a_busy_keeps: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (c_q.st == sfc_pkg::ST_BUSY && c_q.cnt != 32'h0000_0000) |=> c_q.st == sfc_pkg::ST_BUSY)
    else $error("running operation was disturbed");
  a_sleep_holds: assert property (@(posedge core_clk_i) disable iff (reset_i)
    c_q.st == sfc_pkg::ST_SLEEP |=> (c_q.st == sfc_pkg::ST_SLEEP || c_q.st == sfc_pkg::ST_WAKE))
    else $error("deep sleep left without wake opcode");
  a_sleep_entry: assert property (@(posedge core_clk_i) disable iff (reset_i)
    $rose(deep_sleep_o) |-> ($past(c_q.st) == sfc_pkg::ST_SLEEP_ENTER && $past(c_q.cnt) == 32'h0000_0000))
    else $error("deep sleep entered without the entry delay");
  a_standby_idle: assert property (@(posedge core_clk_i) disable iff (reset_i)
    standby_o |-> ($past(c_q.cs2) && c_q.st == sfc_pkg::ST_STANDBY))
    else $error("standby shown while selected or busy");

  // Link-domain checks
  a_sig_repeat: assert property (@(posedge link_sck_i) disable iff (cs_n_i)
    (lk_q.op == sfc_pkg::OP_WAKE_AND_SIGNATURE && lk_q.nbytes >= 3'h4 && lk_q.bcnt == 3'h0 &&
    !lk_q.s2.par) |-> (lk_q.drv && lk_q.tx == SIGNATURE))
    else $error("signature byte not loaded at byte boundary");
  a_so_fall: assert property (@(posedge link_sck_i) disable iff (cs_n_i)
    (lk_q.drv && !lk_q.fetch && !lk_q.s2.par && $past(lk_q.drv)) |-> (so_o == lk_q.tx[7] && so_oe_o))
    else $error("serial out did not follow the falling edge");
  a_par_byte: assert property (@(posedge link_sck_i) disable iff (cs_n_i)
    (lk_q.drv && !lk_q.fetch && lk_q.s2.par && $past(lk_q.drv)) |->
    (parallel_out_bus_o == lk_q.tx && parallel_out_oe_o && !so_oe_o))
    else $error("parallel bus did not carry the whole byte");
endmodule

// >>> core/sfc_pkg.sv
// Package: opcodes, status layout, timing figures and state types of the flash command block
package sfc_pkg;
  // Opcode table
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_FAST_READ = 8'h0B;
  localparam logic [7:0] OP_IDENTIFIER_READ = 8'h9F;
  localparam logic [7:0] OP_MAKER_DEVICE_ID_READ = 8'h90;
  localparam logic [7:0] OP_WRITE_ENABLE_CMD = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE_CMD = 8'h04;
  localparam logic [7:0] OP_BLOCK_WIPE_SMALL = 8'h20;
  localparam logic [7:0] OP_BLOCK_WIPE = 8'hD8;
  localparam logic [7:0] OP_FULL_ARRAY_WIPE = 8'hC7;
  localparam logic [7:0] OP_FULL_ARRAY_WIPE_ALT = 8'h60;
  localparam logic [7:0] OP_PAGE_WRITE = 8'h02;
  localparam logic [7:0] OP_STATUS_FETCH_CMD = 8'h05;
  localparam logic [7:0] OP_STATUS_STORE_CMD = 8'h01;
  localparam logic [7:0] OP_PARALLEL_ENTER = 8'h55;
  localparam logic [7:0] OP_PARALLEL_EXIT = 8'h45;
  localparam logic [7:0] OP_DEEP_SLEEP = 8'hB9;
  localparam logic [7:0] OP_WAKE_AND_SIGNATURE = 8'hAB;

  // Status byte layout and reset values
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_LATCH_BIT = 1;
  localparam int STAT_PROT_LSB = 2;
  localparam int PROT_W = 3;
  localparam logic [2:0] PROT_RESET = 3'h0;
  localparam logic [7:0] FILL_BYTE = 8'hFF;

  // Whole bytes after select at which output data starts, and exact frame lengths
  localparam logic [2:0] START_AFTER_OP = 3'h1;
  localparam logic [2:0] START_AFTER_ADDR = 3'h4;
  localparam logic [2:0] START_AFTER_DUMMY = 3'h5;
  localparam logic [2:0] LEN_CMD = 3'h1;
  localparam logic [2:0] LEN_STORE = 3'h2;
  localparam logic [2:0] LEN_BLOCK = 3'h4;

  // Timing figures and cycle counts at the core clock
  localparam int CORE_PERIOD_NS = 4;
  localparam int SERIAL_MAX_MHZ = 104;
  localparam int PARALLEL_MAX_MHZ = 10;
  localparam int ARRAY_WIPE_TIME_NS = 2000000;
  localparam int BLOCK_WIPE_TIME_NS = 500000;
  localparam int STATUS_STORE_TIME_NS = 50000;
  localparam int SLEEP_ENTRY_DELAY_NS = 3000;
  localparam int WAKE_DELAY_NS = 30000;
  localparam int ARRAY_WIPE_CYC = (ARRAY_WIPE_TIME_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  localparam int BLOCK_WIPE_CYC = (BLOCK_WIPE_TIME_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  localparam int STATUS_STORE_CYC = (STATUS_STORE_TIME_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  localparam int SLEEP_ENTRY_CYC = (SLEEP_ENTRY_DELAY_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  localparam int WAKE_CYC = (WAKE_DELAY_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;

  typedef enum logic [2:0] {ST_STANDBY, ST_BUSY, ST_SLEEP_ENTER, ST_SLEEP, ST_WAKE} sfc_state_t;

  // Levels handed from the core to the link side
  typedef struct packed {
    logic sleep;
    logic par;
    logic [7:0] status;
  } sfc_share_t;

  // Frame summary handed from the link side to the core
  typedef struct packed {
    logic tog;
    logic [7:0] op;
    logic [2:0] nbytes;
    logic [2:0] bcnt;
    logic [7:0] arg;
    logic [23:0] addr;
  } sfc_frame_t;

  typedef struct packed {
    sfc_share_t s1;
    sfc_share_t s2;
    logic [2:0] bcnt;
    logic [2:0] nbytes;
    logic [7:0] sh;
    logic [7:0] op;
    logic [7:0] arg;
    logic [23:0] addr;
    logic [7:0] tx;
    logic [1:0] idsel;
    logic drv;
    logic fetch;
  } sfc_link_t;

  typedef struct packed {
    logic so;
    logic so_oe;
    logic [7:0] pbus;
    logic pbus_oe;
  } sfc_out_t;

  typedef struct packed {
    sfc_state_t st;
    logic seen;
    logic cs1;
    logic cs2;
    logic cs3;
    logic [31:0] cnt;
    logic write_latch;
    logic [2:0] bp;
    logic par;
    logic write_in_progress_flag;
    logic deep;
    logic standby;
    logic erase_all;
    logic erase_blk;
    logic [23:0] eaddr;
    sfc_share_t share;
  } sfc_core_t;
endpackage

// >>> tb/sfc_host_model.sv
// Host serial controller model that frames flash commands
`timescale 1ns/10ps
module sfc_host_model (
  input wire logic so_i,
  input wire logic [7:0] pbus_i,
  output logic cs_n_o,
  output logic sck_o,
  output logic si_o
);
  logic [15:0] prx; // Parallel bytes seen during the answer phase
  initial
  begin
    cs_n_o = 1'b1;
    sck_o = 1'b0;
    si_o = 1'b0;
  end
  // Sends nb bits from the top of d, then clocks nr bits back; clock idles low between frames
  task automatic frame(input logic [39:0] d, input int nb, input int nr, output logic [15:0] rx);
    #($urandom_range(9, 1));
    cs_n_o = 1'b0;
    for (int i = 0; i < nb + nr; i++)
    begin
      si_o = (i < nb) ? d[39 - i] : ~si_o;
      #16;
      if (i >= nb)
      begin
        rx = {rx[14:0], so_i};
        prx = {prx[7:0], pbus_i};
      end
      sck_o = 1'b1;
      #16;
      sck_o = 1'b0;
    end
    #8;
    cs_n_o = 1'b1;
    si_o = ~si_o;
    #100;
  endtask
endmodule

// >>> tb/spi_flash_erase_power_cmds_bench.sv
// Self-checking bench for the flash wipe, sleep and signature commands
`timescale 1ns/10ps
module spi_flash_erase_power_cmds_bench;
  localparam logic [15:0] ID = 16'h3C18; // Arbitrary identifier value
  localparam logic [7:0] MK = 8'h5E; // Arbitrary maker value
  logic core_clk_i, reset_i, link_sck_i, cs_n_i, si_i, so_o;
  logic write_in_progress_flag_o, write_latch_o, parallel_mode_o, deep_sleep_o, standby_o, erase_all_o;
  logic erase_block_o;
  logic [7:0] rd_data_i, pbus;
  logic [7:0] ops [2] = '{8'hC7, 8'h60};
  logic [23:0] rd_addr_o, erase_addr_o, a;
  logic [2:0] protect_level_bits_o, p;
  logic [15:0] rx;
  int errors = 0;
  int compares = 0;

  function automatic logic [7:0] data_at(input logic [23:0] ad);
    return ad[7:0] ^ 8'h5A;
  endfunction
  function automatic logic [7:0] stat(input logic w, input logic l, input logic [2:0] pr);
    return {3'h0, pr, l, w};
  endfunction

  sfc_flash_cmd #(.MAKER_ID(MK), .DEVICE_ID(ID), .ARRAY_WIPE_CYC(200), .BLOCK_WIPE_CYC(200),
    .STATUS_STORE_CYC(20), .WAKE_CYC(20)) dut_u (.core_clk_i, .reset_i, .link_sck_i, .cs_n_i, .si_i,
    .rd_data_i, .so_o, .so_oe_o(), .parallel_out_bus_o(pbus), .parallel_out_oe_o(), .rd_addr_o,
    .write_in_progress_flag_o, .write_latch_o, .protect_level_bits_o, .parallel_mode_o, .deep_sleep_o,
    .standby_o, .erase_all_o, .erase_block_o, .erase_addr_o);
  sfc_host_model host_u (.so_i(so_o), .pbus_i(pbus), .cs_n_o(cs_n_i), .sck_o(link_sck_i), .si_o(si_i));
  // Array content is a simple function of the address
  assign rd_data_i = data_at(rd_addr_o);

  task automatic check(input logic [23:0] seen, input logic [23:0] exp, input string m);
    compares++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  task automatic cmd(input logic [7:0] op);
    host_u.frame({op, 32'h0}, 8, 0, rx);
  endtask
  task automatic settle(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask
  task automatic give_verdict();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Core clock and watchdog
  initial
  begin
    core_clk_i = 1'b0;
    forever #2 core_clk_i = ~core_clk_i;
  end
  initial
  begin
    #200000;
    errors++;
    give_verdict();
  end

  // Test sequence
  initial
  begin
    reset_i = 1'b1;
    void'($urandom(32'hd23e));
    settle(2);
    reset_i = 1'b0;
    settle(3);
    check({deep_sleep_o, parallel_mode_o, write_latch_o, write_in_progress_flag_o}, 4'h0, "reset");
    cmd(8'hC7);
    settle(4);
    check(write_in_progress_flag_o, 1'h0, "wipe without latch");
    foreach (ops[i])
    begin
      cmd(8'h06);
      check(write_latch_o, 1'h1, "latch set");
      cmd(ops[i]);
      settle(4);
      check({erase_all_o, write_in_progress_flag_o, write_latch_o}, 3'h6, "wipe running");
      cmd(8'hB9);
      for (int k = 0; k < 2000 && write_in_progress_flag_o !== 1'b0; k++)
        settle(1);
      settle(800);
      check({erase_all_o, deep_sleep_o}, 2'h0, "wipe done, sleep refused");
    end
    cmd(8'h06);
    host_u.frame({8'hC7, 32'h0}, 9, 0, rx);
    settle(4);
    check(write_in_progress_flag_o, 1'h0, "nine bit wipe");
    $display("test wipe done");
    p = 3'($urandom_range(7, 1));
    cmd(8'h06);
    host_u.frame({8'h01, 3'h0, p, 2'h0, 24'h0}, 16, 0, rx);
    settle(40);
    cmd(8'h06);
    host_u.frame({8'h05, 32'h0}, 8, 8, rx);
    check(rx[7:0], stat(1'h0, 1'h1, p), "status byte");
    cmd(8'hC7);
    settle(4);
    check(erase_all_o, 1'h0, "protected wipe");
    cmd(8'h06);
    host_u.frame({8'h01, 32'h0}, 16, 0, rx);
    settle(40);
    check(protect_level_bits_o, 3'h0, "protect cleared");
    // Block wipe with either opcode at a random address
    cmd(8'h06);
    a = 24'($urandom);
    host_u.frame({($urandom_range(1, 0) ? 8'h20 : 8'hD8), a, 8'h0}, 32, 0, rx);
    settle(4);
    check({erase_block_o, write_in_progress_flag_o}, 2'h3, "block wipe running");
    check(erase_addr_o, a, "block wipe address");
    settle(200);
    $display("test protect done");
    for (int i = 0; i < 2; i++)
    begin
      a = 24'($urandom);
      host_u.frame({i ? 8'h0B : 8'h03, a, 8'h0}, 32 + 8 * i, 8, rx);
      check(rx[7:0], data_at(a), "read byte");
    end
    host_u.frame({8'h9F, 32'h0}, 8, 16, rx);
    check(rx, {MK, ID[15:8]}, "identifier bytes");
    host_u.frame({8'h90, a, 8'h0}, 32, 16, rx);
    check(rx, a[0] ? {ID[7:0], MK} : {MK, ID[7:0]}, "maker and device codes");
    cmd(8'h55);
    check(parallel_mode_o, 1'h1, "parallel on");
    host_u.frame({8'hAB, 32'h0}, 32, 2, rx);
    check(host_u.prx, {2{ID[7:0]}}, "parallel signature");
    cmd(8'h45);
    check(parallel_mode_o, 1'h0, "parallel off");
    $display("test read done");
    cmd(8'hB9);
    for (int k = 0; k < 1000 && deep_sleep_o !== 1'b1; k++)
      settle(1);
    check(deep_sleep_o, 1'h1, "sleep entered");
    cmd(8'h06);
    check(write_latch_o, 1'h0, "ignored in sleep");
    host_u.frame({8'hAB, 32'h0}, 32, 16, rx);
    check(rx, {2{ID[7:0]}}, "signature");
    settle(40);
    check({deep_sleep_o, standby_o}, 2'h1, "awake standby");
    $display("test sleep done");
    give_verdict();
  end
endmodule
